// file: rtl/fast_timer_defines.svh
// Offsets, field positions, reset values and timing counts of the fast timer
`ifndef FAST_TIMER_DEFINES_SVH
`define FAST_TIMER_DEFINES_SVH

// I/O offsets
`define FT_OFF_DEAD_TIME 6'h24
`define FT_OFF_HIGH_TEMP 6'h25
`define FT_OFF_CMP_D 6'h2a
`define FT_OFF_TOP 6'h2b
`define FT_OFF_CMP_B 6'h2c
`define FT_OFF_CMP_A 6'h2d
`define FT_OFF_COUNTER 6'h2e
`define FT_OFF_EVENT_FLAGS 6'h38
`define FT_OFF_IRQ_MASK 6'h39

// Bit positions in mask and flag registers
`define FT_BIT_MATCH_D 7
`define FT_BIT_MATCH_A 6
`define FT_BIT_MATCH_B 5
`define FT_BIT_WRAP 2

// Dead-time fields
`define FT_DT_HIGH_MSB 7
`define FT_DT_HIGH_LSB 4
`define FT_DT_LOW_MSB 3
`define FT_DT_LOW_LSB 0

// Reset values
`define FT_RST_DEAD_TIME 8'h00
`define FT_RST_IRQ_MASK 8'h00
`define FT_RST_CMP 8'h00
`define FT_RST_TOP 8'hff

// Smallest period value stored
`define FT_TOP_MIN 8'h03

// Counter write latency in clock cycles (1.5 rounds up to 2)
`define FT_LOAD_DELAY_SYNC 2
`define FT_LOAD_DELAY_ASYNC 1

`endif

// file: rtl/fast_timer_pkg.sv
// Types shared by the fast timer
package fast_timer_pkg;

  typedef enum logic [2:0] {
    mode_normal = 3'b000,
    mode_fast_pwm = 3'b001,
    mode_phase_freq = 3'b010,
    mode_six_single = 3'b011,
    mode_six_dual = 3'b100
  } count_mode_e;

  typedef enum logic [0:0] {
    dir_up = 1'b0,
    dir_down = 1'b1
  } count_dir_e;

  // Compare slots: A, B, period (C), D
  typedef logic [1:0] cmp_slot_t;

endpackage

// file: rtl/fast_timer.sv
// Fast 10-bit timer core: counter, compare registers, flags and dead-time value
`timescale 1ns/100ps
`default_nettype none
`include "fast_timer_defines.svh"

// What this block does
// RL1: Ten-bit up/down counter, software readable and writable
// RL2: Counter write lands after two or one cycles
// RL3: Counter write restarts counting upward
// RL4: Temp register holds high bits, upper zero
// RL5: Low byte alone gives plain 8-bit operation
// RL6: A, B, D match only while counting
// RL7: Software write into equality never matches
// RL8: Match sets flag one cycle later
// RL9: Period match clears counter in single-slope modes
// RL10: Period writes below three store three
// RL11: Mask at 0x39: D7 A6 B5 wrap2
// RL12: Flags: D7 A6 B5 wrap2
// RL13: Flag cleared by vector or write-one
// RL14: Request needs global, enable and flag
// RL15: Single-slope modes flag wrap at top
// RL16: Dual-slope modes flag wrap at bottom
// RL17: Dead-time at 0x24, high 7:4, low 3:0
// RL18: Dead-time fields serve every channel
// RL19: PWM enables and mode bits pick mode
// RL20: Dead-time field counts zero to fifteen ticks
// RL21: Software writes temp first, then low byte
// RL22: Dual-slope counts up to period, down
module fast_timer #(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // I/O register port
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Mode and clocking controls
  input wire logic channel_pwm_enables,
  input wire logic [1:0] waveform_mode_select,
  input wire logic async_clock_mode,
  input wire logic count_tick,
  // Interrupt handshake
  input wire logic global_irq_enable,
  input wire logic ack_match_a,
  input wire logic ack_match_b,
  input wire logic ack_match_d,
  input wire logic ack_wrap,
  output logic irq_match_a,
  output logic irq_match_b,
  output logic irq_match_d,
  output logic irq_wrap,
  // Counter state and dead-time fields
  output logic [CNT_W-1:0] counter_out,
  output logic count_down,
  output logic [3:0] dead_time_high_field,
  output logic [3:0] dead_time_low_field
);

  localparam int HI_W = CNT_W - 8;

  initial begin
    if (CNT_W < 9 || CNT_W > 16) begin
      $error("fast_timer: CNT_W must lie between 9 and 16");
    end
  end

  // ==========================================================
  // Helpers
  // Internal event order is {D, A, B, wrap}
  function automatic logic [7:0] to_byte(input logic [3:0] v);
    logic [7:0] b;
    b = 8'h00;
    b[`FT_BIT_MATCH_D] = v[3];
    b[`FT_BIT_MATCH_A] = v[2];
    b[`FT_BIT_MATCH_B] = v[1];
    b[`FT_BIT_WRAP] = v[0];
    return b;
  endfunction

  function automatic logic [3:0] from_byte(input logic [7:0] b);
    return {b[`FT_BIT_MATCH_D], b[`FT_BIT_MATCH_A], b[`FT_BIT_MATCH_B], b[`FT_BIT_WRAP]};
  endfunction

  function automatic logic [CNT_W-1:0] widen(input logic [HI_W-1:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

  // ==========================================================
  // Register state
  logic [HI_W-1:0] high_temp_r;
  logic [7:0] dead_time_r;
  logic [3:0] irq_mask_r;
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic [3:0] clr_pend_r;
  logic [3:0] match_r;
  logic [CNT_W-1:0] cmp_buf_r [4];
  logic [CNT_W-1:0] cmp_act_r [4];
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  fast_timer_pkg::count_dir_e dir_r;
  fast_timer_pkg::count_dir_e dir_nxt;
  fast_timer_pkg::count_mode_e mode;
  logic [7:0] rdata_r;
  logic [3:0] irq_r;

  // Counter load pipeline
  logic ld1_v_r;
  logic ld1_async_r;
  logic [CNT_W-1:0] ld1_d_r;
  logic ld2_v_r;
  logic [CNT_W-1:0] ld2_d_r;
  logic load_now;
  logic [CNT_W-1:0] load_val;

  // Step control
  logic step;
  logic dual;
  logic wrap_evt;
  logic top_evt;
  logic bottom_evt;
  logic cmp_update;
  logic [CNT_W-1:0] top;
  logic [CNT_W-1:0] wr_val;
  logic [CNT_W-1:0] top_wr_val;

  // ==========================================================
  // Mode decode
  always_comb begin
    if (!channel_pwm_enables) begin
      mode = fast_timer_pkg::mode_normal; // [RL19]
    end else begin
      case (waveform_mode_select)
        2'b00: mode = fast_timer_pkg::mode_fast_pwm;
        2'b01: mode = fast_timer_pkg::mode_phase_freq;
        2'b10: mode = fast_timer_pkg::mode_six_single;
        default: mode = fast_timer_pkg::mode_six_dual;
      endcase
    end
  end

  assign dual = (mode == fast_timer_pkg::mode_phase_freq) ||
                (mode == fast_timer_pkg::mode_six_dual);
  assign top = cmp_act_r[2];
  assign wr_val = widen(high_temp_r, io_wdata); // [RL21]
  assign top_wr_val = (wr_val < CNT_W'(`FT_TOP_MIN)) ? CNT_W'(`FT_TOP_MIN) : wr_val; // [RL10]

  // ==========================================================
  // Counter write pipeline
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ld1_v_r <= 1'b0;
      ld1_async_r <= 1'b0;
      ld1_d_r <= '0;
      ld2_v_r <= 1'b0;
      ld2_d_r <= '0;
    end else begin
      ld1_v_r <= io_wr && (io_addr == `FT_OFF_COUNTER);
      ld1_async_r <= async_clock_mode;
      ld1_d_r <= wr_val;
      ld2_v_r <= ld1_v_r && !ld1_async_r; // [RL2]
      ld2_d_r <= ld1_d_r;
    end
  end

  assign load_now = (ld1_v_r && ld1_async_r) || ld2_v_r; // [RL2]
  assign load_val = ld2_v_r ? ld2_d_r : ld1_d_r;
  assign step = count_tick && !load_now; // [RL6] [RL7]

  // ==========================================================
  // Counting sequence
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    top_evt = 1'b0;
    bottom_evt = 1'b0;
    if (load_now) begin
      cnt_nxt = load_val; // [RL1]
      dir_nxt = fast_timer_pkg::dir_up; // [RL3]
    end else if (step) begin
      if (!dual) begin
        if (cnt_r == top) begin
          cnt_nxt = '0; // [RL9]
          top_evt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end else if (dir_r == fast_timer_pkg::dir_up) begin
        if (cnt_r >= top) begin
          cnt_nxt = cnt_r - CNT_W'(1); // [RL22]
          dir_nxt = fast_timer_pkg::dir_down;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end else begin
        cnt_nxt = cnt_r - CNT_W'(1); // [RL22]
        if (cnt_r == CNT_W'(1)) begin
          bottom_evt = 1'b1;
          dir_nxt = fast_timer_pkg::dir_up;
        end
      end
    end
  end

  assign wrap_evt = dual ? bottom_evt : top_evt; // [RL15] [RL16]

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      dir_r <= fast_timer_pkg::dir_up;
    end else begin
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
    end
  end

  // ==========================================================
  // Compare registers: buffered, applied per mode
  always_comb begin
    case (mode)
      fast_timer_pkg::mode_normal: cmp_update = 1'b1;
      fast_timer_pkg::mode_fast_pwm: cmp_update = top_evt;
      fast_timer_pkg::mode_six_single: cmp_update = top_evt;
      default: cmp_update = bottom_evt;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        cmp_buf_r[i] <= (i == 2) ? CNT_W'(`FT_RST_TOP) : CNT_W'(`FT_RST_CMP);
      end
    end else if (io_wr) begin
      if (io_addr == `FT_OFF_CMP_A) begin
        cmp_buf_r[0] <= wr_val; // [RL5]
      end else if (io_addr == `FT_OFF_CMP_B) begin
        cmp_buf_r[1] <= wr_val;
      end else if (io_addr == `FT_OFF_TOP) begin
        cmp_buf_r[2] <= top_wr_val; // [RL10]
      end else if (io_addr == `FT_OFF_CMP_D) begin
        cmp_buf_r[3] <= wr_val;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        cmp_act_r[i] <= (i == 2) ? CNT_W'(`FT_RST_TOP) : CNT_W'(`FT_RST_CMP);
      end
    end else if (cmp_update) begin
      for (int i = 0; i < 4; i++) begin
        cmp_act_r[i] <= cmp_buf_r[i];
      end
    end
  end

  // ==========================================================
  // Match detection, only on counting steps
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      match_r <= 4'h0;
    end else begin
      match_r[3] <= step && (cnt_nxt == cmp_act_r[3]); // [RL6] [RL7]
      match_r[2] <= step && (cnt_nxt == cmp_act_r[0]);
      match_r[1] <= step && (cnt_nxt == cmp_act_r[1]);
      match_r[0] <= wrap_evt;
    end
  end

  // ==========================================================
  // Event flags: set wins over any clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clr_pend_r <= 4'h0;
    end else if (io_wr && (io_addr == `FT_OFF_EVENT_FLAGS)) begin
      clr_pend_r <= from_byte(io_wdata); // [RL13]
    end else begin
      clr_pend_r <= 4'h0;
    end
  end

  always_comb begin
    flags_nxt = flags_r & ~clr_pend_r; // [RL13]
    flags_nxt = flags_nxt & ~{ack_match_d, ack_match_a, ack_match_b, ack_wrap}; // [RL13]
    flags_nxt = flags_nxt | match_r; // [RL8] [RL12]
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 4'h0;
    end else begin
      irq_r <= {4{global_irq_enable}} & irq_mask_r & flags_r; // [RL14]
    end
  end

  // ==========================================================
  // Mask, dead-time and temp registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_r <= from_byte(`FT_RST_IRQ_MASK);
    end else if (io_wr && (io_addr == `FT_OFF_IRQ_MASK)) begin
      irq_mask_r <= from_byte(io_wdata); // [RL11]
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dead_time_r <= `FT_RST_DEAD_TIME;
    end else if (io_wr && (io_addr == `FT_OFF_DEAD_TIME)) begin
      dead_time_r <= io_wdata; // [RL17] [RL20]
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      high_temp_r <= '0;
    end else if (io_wr && (io_addr == `FT_OFF_HIGH_TEMP)) begin
      high_temp_r <= io_wdata[HI_W-1:0]; // [RL4]
    end else if (io_rd) begin
      if (io_addr == `FT_OFF_COUNTER) begin
        high_temp_r <= cnt_r[CNT_W-1:8]; // [RL21]
      end else if (io_addr == `FT_OFF_CMP_A) begin
        high_temp_r <= cmp_buf_r[0][CNT_W-1:8];
      end else if (io_addr == `FT_OFF_CMP_B) begin
        high_temp_r <= cmp_buf_r[1][CNT_W-1:8];
      end else if (io_addr == `FT_OFF_TOP) begin
        high_temp_r <= cmp_buf_r[2][CNT_W-1:8];
      end else if (io_addr == `FT_OFF_CMP_D) begin
        high_temp_r <= cmp_buf_r[3][CNT_W-1:8];
      end
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else if (io_rd) begin
      if (io_addr == `FT_OFF_COUNTER) begin
        rdata_r <= cnt_r[7:0]; // [RL1] [RL5]
      end else if (io_addr == `FT_OFF_HIGH_TEMP) begin
        rdata_r <= 8'(high_temp_r); // [RL4]
      end else if (io_addr == `FT_OFF_CMP_A) begin
        rdata_r <= cmp_buf_r[0][7:0];
      end else if (io_addr == `FT_OFF_CMP_B) begin
        rdata_r <= cmp_buf_r[1][7:0];
      end else if (io_addr == `FT_OFF_TOP) begin
        rdata_r <= cmp_buf_r[2][7:0];
      end else if (io_addr == `FT_OFF_CMP_D) begin
        rdata_r <= cmp_buf_r[3][7:0];
      end else if (io_addr == `FT_OFF_IRQ_MASK) begin
        rdata_r <= to_byte(irq_mask_r); // [RL11]
      end else if (io_addr == `FT_OFF_EVENT_FLAGS) begin
        rdata_r <= to_byte(flags_r); // [RL12]
      end else if (io_addr == `FT_OFF_DEAD_TIME) begin
        rdata_r <= dead_time_r;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign io_rdata = rdata_r;
  assign irq_match_d = irq_r[3];
  assign irq_match_a = irq_r[2];
  assign irq_match_b = irq_r[1];
  assign irq_wrap = irq_r[0];
  assign counter_out = cnt_r;
  assign count_down = (dir_r == fast_timer_pkg::dir_down);
  // One pair of fields drives every channel's dead-time generator
  assign dead_time_high_field = dead_time_r[`FT_DT_HIGH_MSB:`FT_DT_HIGH_LSB]; // [RL18]
  assign dead_time_low_field = dead_time_r[`FT_DT_LOW_MSB:`FT_DT_LOW_LSB]; // [RL18]

endmodule // fast_timer

`default_nettype wire

// file: test/fast_timer_props.sv
// Port checker for the fast timer core
`timescale 1ns/100ps
`default_nettype none
`include "fast_timer_defines.svh"
module fast_timer_props #(
  parameter int CNT_W = 10
) (
  // Clock, reset and register port
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // Controls and requests
  input wire logic channel_pwm_enables,
  input wire logic async_clock_mode,
  input wire logic count_tick,
  input wire logic global_irq_enable,
  input wire logic ack_match_a,
  input wire logic irq_match_a,
  input wire logic irq_match_d,
  input wire logic irq_wrap,
  // Counter state and dead-time fields
  input wire logic [CNT_W-1:0] counter_out,
  input wire logic count_down,
  input wire logic [3:0] dead_time_high_field,
  input wire logic [3:0] dead_time_low_field
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ====================
  // Sequences
  sequence cnt_wr_s;
    io_wr && io_addr == `FT_OFF_COUNTER;
  endsequence
  sequence quiet_s;
    !io_wr && !$past(io_wr) && !$past(io_wr, 2);
  endsequence
  // ====================
  // Properties
  rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data changed without a read");
  sync_load_a: assert property (cnt_wr_s ##0 !async_clock_mode |-> ##3
    (counter_out[7:0] == $past(io_wdata, 3) && !count_down))
    else $error("sync counter write not applied after two cycles");
  async_load_a: assert property (cnt_wr_s ##0 async_clock_mode |-> ##2
    counter_out[7:0] == $past(io_wdata, 2)) else $error("async counter write late");
  up_step_a: assert property ((count_tick && !count_down && !channel_pwm_enables)
    ##0 quiet_s |=> (counter_out == $past(counter_out) + 1'b1 || counter_out == '0))
    else $error("counter did not step up");
  down_step_a: assert property ((count_tick && count_down && counter_out != '0)
    ##0 quiet_s |=> counter_out == $past(counter_out) - 1'b1)
    else $error("counter did not step down");
  normal_up_a: assert property (!channel_pwm_enables && !$past(channel_pwm_enables)
    |-> !count_down) else $error("down count in normal mode");
  irq_global_a: assert property ((irq_match_a || irq_match_d || irq_wrap)
    |-> $past(global_irq_enable)) else $error("request without global enable");
  ack_clear_a: assert property (ack_match_a && !count_tick && !$past(count_tick)
    |-> ##2 !irq_match_a) else $error("vector did not clear request");
  flag_clear_a: assert property (io_wr && io_addr == `FT_OFF_EVENT_FLAGS
    && io_wdata[7] && !count_tick |-> ##3 !irq_match_d)
    else $error("write one did not clear flag");
  dt_field_a: assert property (io_wr && io_addr == `FT_OFF_DEAD_TIME |-> ##2
    {dead_time_high_field, dead_time_low_field} == $past(io_wdata, 2))
    else $error("dead time fields wrong");
endmodule // fast_timer_props

bind fast_timer fast_timer_props #(.CNT_W(CNT_W)) i_props (
  .mclk(mclk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .channel_pwm_enables(channel_pwm_enables),
  .async_clock_mode(async_clock_mode), .count_tick(count_tick),
  .global_irq_enable(global_irq_enable), .ack_match_a(ack_match_a),
  .irq_match_a(irq_match_a), .irq_match_d(irq_match_d), .irq_wrap(irq_wrap),
  .counter_out(counter_out), .count_down(count_down),
  .dead_time_high_field(dead_time_high_field), .dead_time_low_field(dead_time_low_field)
);
`default_nettype wire

// file: test/fast_timer_tb.sv
// Self-checking bench for the fast timer core
`timescale 1ns/100ps
`default_nettype none
`include "fast_timer_defines.svh"
`define chk_eq(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module fast_timer_tb;
  logic mclk, arst_n, io_wr, io_rd, pwm, async_mode, tick, gie, ack_a, ack_w, down, rd_seen;
  logic [5:0] io_addr;
  logic [7:0] io_wdata, io_rdata, rnd, exp_v;
  logic [1:0] wms;
  logic [9:0] cnt;
  logic [3:0] dt_h, dt_l, irq;
  logic [7:0] exp_q[$];
  int n_mismatch, samples_checked;

  fast_timer i_dut (
    .mclk(mclk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .channel_pwm_enables(pwm),
    .waveform_mode_select(wms), .async_clock_mode(async_mode), .count_tick(tick),
    .global_irq_enable(gie), .ack_match_a(ack_a), .ack_match_b(1'b0), .ack_match_d(1'b0),
    .ack_wrap(ack_w), .irq_match_a(irq[2]), .irq_match_b(irq[1]), .irq_match_d(irq[3]),
    .irq_wrap(irq[0]), .counter_out(cnt), .count_down(down),
    .dead_time_high_field(dt_h), .dead_time_low_field(dt_l)
  );

  // ====================
  // Tasks
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge mclk);
    io_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge mclk);
    io_rd <= 1'b0;
  endtask
  task automatic step(input int n);
    @(posedge mclk);
    tick <= 1'b1;
    repeat (n) @(posedge mclk);
    tick <= 1'b0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic stop_test();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ====================
  // Clock, watcher, watchdog
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) rd_seen <= io_rd;
  always @(negedge mclk) begin
    if (rd_seen === 1'b1) begin
      exp_v = exp_q.pop_front();
      `chk_eq(io_rdata, exp_v)
    end
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end

  // ====================
  // Main sequence
  initial begin
    {arst_n, io_wr, io_rd, pwm, async_mode, tick, gie, ack_a, ack_w, rd_seen} = '0;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    wms = 2'b00;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    rd(`FT_OFF_DEAD_TIME, 8'h00);
    rd(`FT_OFF_IRQ_MASK, 8'h00);
    rd(`FT_OFF_HIGH_TEMP, 8'h00);
    rd(`FT_OFF_EVENT_FLAGS, 8'h00);
    rd(6'h3f, 8'h00);
    rnd = lfsr(8'h3f);
    wr(`FT_OFF_DEAD_TIME, rnd);
    rd(`FT_OFF_DEAD_TIME, rnd);
    wait_n(0);
    `chk_eq({dt_h, dt_l}, rnd)
    rnd = lfsr(rnd);
    wr(`FT_OFF_IRQ_MASK, rnd);
    rd(`FT_OFF_IRQ_MASK, rnd & 8'he4);
    wr(`FT_OFF_HIGH_TEMP, 8'hff);
    rd(`FT_OFF_HIGH_TEMP, 8'h03);
    wr(`FT_OFF_HIGH_TEMP, 8'h00);
    wr(`FT_OFF_TOP, 8'h01);
    rd(`FT_OFF_TOP, 8'h03);
    // Ten-bit counter load, sync then async
    wr(`FT_OFF_HIGH_TEMP, 8'h02);
    wr(`FT_OFF_COUNTER, 8'h34);
    wait_n(1);
    `chk_eq(cnt, 10'h000)
    wait_n(1);
    `chk_eq(cnt, 10'h234)
    rd(`FT_OFF_COUNTER, 8'h34);
    rd(`FT_OFF_HIGH_TEMP, 8'h02);
    @(posedge mclk);
    async_mode <= 1'b1;
    wr(`FT_OFF_HIGH_TEMP, 8'h00);
    wr(`FT_OFF_COUNTER, 8'h55);
    wait_n(1);
    `chk_eq(cnt, 10'h055)
    async_mode <= 1'b0;
    // Normal mode count and wrap
    wr(`FT_OFF_TOP, 8'h0a);
    wr(`FT_OFF_CMP_A, 8'h03);
    wr(`FT_OFF_CMP_B, 8'h05);
    wr(`FT_OFF_CMP_D, 8'h07);
    wr(`FT_OFF_COUNTER, 8'h00);
    wr(`FT_OFF_EVENT_FLAGS, 8'hff);
    step(10);
    wait_n(0);
    `chk_eq(cnt, 10'h00a)
    step(1);
    wait_n(0);
    `chk_eq(cnt, 10'h000)
    rd(`FT_OFF_EVENT_FLAGS, 8'he4);
    // Requests, vector and write-one clears
    wr(`FT_OFF_IRQ_MASK, 8'he4);
    @(posedge mclk);
    gie <= 1'b1;
    wait_n(3);
    `chk_eq(irq, 4'hf)
    gie <= 1'b0;
    wait_n(3);
    `chk_eq(irq, 4'h0)
    {gie, ack_a, ack_w} <= 3'b111;
    @(posedge mclk);
    {ack_a, ack_w} <= 2'b00;
    wait_n(3);
    `chk_eq(irq, 4'ha)
    wr(`FT_OFF_EVENT_FLAGS, 8'h80);
    wait_n(1);
    rd(`FT_OFF_EVENT_FLAGS, 8'h20);
    wr(`FT_OFF_EVENT_FLAGS, 8'hff);
    wr(`FT_OFF_COUNTER, 8'h03);
    wait_n(3);
    rd(`FT_OFF_EVENT_FLAGS, 8'h00);
    // Dual-slope counting
    {pwm, wms} <= 3'b101;
    wr(`FT_OFF_COUNTER, 8'h00);
    wr(`FT_OFF_EVENT_FLAGS, 8'hff);
    step(12);
    wait_n(0);
    `chk_eq({down, cnt}, {1'b1, 10'h008})
    wr(`FT_OFF_COUNTER, 8'h05);
    wait_n(2);
    `chk_eq(down, 1'b0)
    wr(`FT_OFF_EVENT_FLAGS, 8'hff);
    step(5);
    rd(`FT_OFF_EVENT_FLAGS, 8'h80);
    wr(`FT_OFF_EVENT_FLAGS, 8'hff);
    step(10);
    rd(`FT_OFF_EVENT_FLAGS, 8'he4);
    wait_n(2);
    stop_test();
  end
endmodule // fast_timer_tb
`default_nettype wire
